// >>> gtd_cfg.svh
// Timing, threshold and register map constants for the gear-tooth encoder
`ifndef GTD_ENCODER_CFG_SVH
`define GTD_ENCODER_CFG_SVH

// ----------------------------------------------------------------
// Clock and pulse timing
// ----------------------------------------------------------------
`define GTD_CLK_MHZ 10
`define GTD_CLK_HZ 10000000
`define GTD_CW 24
`define GTD_FWD_US 60
`define GTD_REV_US 180
`define GTD_ND_US 360
`define GTD_SEP_US 20
`define GTD_ERR_US 300
`define GTD_ERR_GAP_US 400
`define GTD_SETTLE_US 2000
`define GTD_TRST_MS 500
`define GTD_DIRLIM_HZ 1500
`define GTD_FWD_CYC (`GTD_FWD_US * `GTD_CLK_MHZ)
`define GTD_REV_CYC (`GTD_REV_US * `GTD_CLK_MHZ)
`define GTD_ND_CYC (`GTD_ND_US * `GTD_CLK_MHZ)
`define GTD_SEP_CYC (`GTD_SEP_US * `GTD_CLK_MHZ)
`define GTD_ERR_CYC (`GTD_ERR_US * `GTD_CLK_MHZ)
`define GTD_ERR_GAP_CYC (`GTD_ERR_GAP_US * `GTD_CLK_MHZ)
`define GTD_SETTLE_CYC (`GTD_SETTLE_US * `GTD_CLK_MHZ)
`define GTD_TRST_CYC (`GTD_TRST_MS * `GTD_CLK_MHZ * 1000)
`define GTD_DIRLIM_CYC (`GTD_CLK_HZ / `GTD_DIRLIM_HZ)

// ----------------------------------------------------------------
// Channel switching levels and start-up
// ----------------------------------------------------------------
`define GTD_ON_PCT 16'h0046
`define GTD_OFF_PCT 16'h001e
`define GTD_PCT_DIV 16'h0064
`define GTD_PK_HI_RST 8'h00
`define GTD_PK_LO_RST 8'hff
`define GTD_CAL_TEETH 2'h2

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define GTD_REG_CTRL 8'h00
`define GTD_REG_STATUS 8'h04
`define GTD_REG_COUNT 8'h08
`define GTD_CTRL_RST 4'h0
`define GTD_CTRL_POL 0
`define GTD_CTRL_INTER 1
`define GTD_CTRL_DIAG 2
`define GTD_CTRL_TRST 3

`endif

// >>> gtd_ctl_model.sv
// Controller model that decodes the encoder pulse stream by width and gap
`timescale 1ns/1ps
`include "gtd_cfg.svh"
module gtd_ctl_model #(
  parameter int SETTLE_CYC = 20 // Cycles after reset before the output is trusted
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic pulse, // Current pulse from the encoder
  output int n_kind [4], // Pulses seen per kind: fwd, rev, non-dir, error
  output int n_odd // Pulses of unknown width or after too short a gap
);
  int age;
  int hi_len;
  int lo_len;
  int need;
  logic prev;

  // Measure each high phase and the low gap before it, in core cycles
  always @(posedge clk) begin
    if (rst) begin
      age = 0;
      hi_len = 0;
      lo_len = 1 << 20;
      need = `GTD_SEP_CYC;
      prev = 1'b0;
      n_kind = '{default: 0};
      n_odd = 0;
    end else if (age < SETTLE_CYC) begin
      age++;
    end else if (pulse) begin
      if (!prev && lo_len < need) n_odd++;
      hi_len++;
      prev = 1'b1;
    end else begin
      // Width alone tells the kind; the count of pulses gives the speed
      if (prev) begin
        case (hi_len)
          `GTD_FWD_CYC: n_kind[0]++;
          `GTD_REV_CYC: n_kind[1]++;
          `GTD_ND_CYC: n_kind[2]++;
          `GTD_ERR_CYC: n_kind[3]++;
          default: n_odd++;
        endcase
        // An error frame asks for the long low phase before the next pulse
        need = (hi_len == `GTD_ERR_CYC) ? `GTD_ERR_GAP_CYC : `GTD_SEP_CYC;
        hi_len = 0;
        lo_len = 0;
      end
      lo_len++;
      prev = 1'b0;
    end
  end
endmodule

// >>> gtd_encoder.sv
// Gear-tooth speed and direction pulse encoder core
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "gtd_cfg.svh"

// Summary of operation
// - One output pulse per target tooth passing the sensing face.
// - Speed is carried only by pulse repetition rate.
// - Direction is carried by pulse duration; controller measures it.
// - Direction comes from relative phase of the two channels.
// - One switching order means forward, the opposite order reverse.
// - Forward teeth give a forward-length pulse.
// - Reverse teeth give a distinct reverse-length pulse.
// - Polarity option swaps which order reports forward.
// - Intermediate option drops direction above the direction rate limit.
// - Pulses stay separated; that limits the highest pulse rate.
// - Diagnostic variant monitors for internal defects continuously.
// - Monitor flag or channel-order faults replace normal pulses with error protocol.
// - Recovery is retried without limit while a fault persists.
// - Timed-reset variant resets periodically; no zero-speed guarantee.
// - Timed reset fires after about 0.5 s with no pulses.
// - First valid pulse within four target cycles after power-on.
// - Channel on at 70 percent, off at 30 percent of span.
module gtd_encoder #(
  parameter int unsigned SETTLE_CYC = `GTD_SETTLE_CYC, // Power-on settle in cycles
  parameter int unsigned TRST_CYC = `GTD_TRST_CYC, // Idle time before timed reset
  parameter int unsigned DIRLIM_CYC = `GTD_DIRLIM_CYC // Shortest tooth period with direction
) (
  input wire logic CORE_CLK, // Core clock, 10 MHz
  input wire logic SYS_RST, // Synchronous reset, active high
  input wire logic CLK_EN, // Clock enable, freezes all state when low
  input wire logic [7:0] SIG_A, // Processed channel A sample, core clock
  input wire logic [7:0] SIG_B, // Processed channel B sample, core clock
  input wire logic FAULT_IN, // Asynchronous defect flag from monitors
  input wire logic [7:0] ADDR, // Register byte address
  input wire logic [31:0] WDATA, // Register write data
  input wire logic WR, // Register write strobe
  input wire logic RD, // Register read strobe
  output logic [31:0] RDATA, // Read data, cycle after RD
  output logic PULSE_OUT // High-current phase of output
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] ctrl;
  logic fault_sync;
  logic [7:0] smp [2];
  logic [7:0] pk_hi [2];
  logic [7:0] pk_lo [2];
  logic ch [2];
  logic ch_q [2];
  logic rise [2];
  logic b_led;
  logic phase_err;
  logic settled;
  logic [`GTD_CW-1:0] settle_cnt;
  logic [1:0] cal_cnt;
  logic calibrated;
  logic [`GTD_CW-1:0] per_cnt;
  logic [`GTD_CW-1:0] idle_cnt;
  logic trst_hit;
  logic tooth;
  logic dir_fwd;
  logic last_fwd;
  gtd_pkg::gtd_kind_t next_kind;
  logic pend;
  gtd_pkg::gtd_kind_t pend_kind;
  gtd_pkg::gtd_out_t ost;
  gtd_pkg::gtd_kind_t cur_kind;
  logic [`GTD_CW-1:0] tcnt;
  logic fault_now;
  logic fault_state;
  logic [15:0] pulse_cnt;
  logic [7:0] retry_cnt;
  logic start;
  logic gap_done;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Switching level as a percentage of the tracked peak-to-peak span
  function automatic logic [7:0] gtd_level(input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [15:0] pct);
    logic [15:0] prod;
    prod = 16'(hi - lo) * pct;
    gtd_level = lo + 8'(prod / `GTD_PCT_DIV);
  endfunction

  // High time of a pulse by kind
  function automatic logic [`GTD_CW-1:0] gtd_len(input gtd_pkg::gtd_kind_t k);
    unique case (k)
      gtd_pkg::GTD_FWD: gtd_len = `GTD_CW'(`GTD_FWD_CYC);
      gtd_pkg::GTD_REV: gtd_len = `GTD_CW'(`GTD_REV_CYC);
      gtd_pkg::GTD_ND: gtd_len = `GTD_CW'(`GTD_ND_CYC);
      gtd_pkg::GTD_ERR: gtd_len = `GTD_CW'(`GTD_ERR_CYC);
    endcase
  endfunction

  // Low gap after a pulse by kind; error frames use a longer gap
  function automatic logic [`GTD_CW-1:0] gtd_gap(input gtd_pkg::gtd_kind_t k);
    gtd_gap = (k == gtd_pkg::GTD_ERR) ? `GTD_CW'(`GTD_ERR_GAP_CYC) : `GTD_CW'(`GTD_SEP_CYC);
  endfunction

  // ----------------------------------------------------------------
  // Inputs
  // ----------------------------------------------------------------
  gtd_sync u_fault_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .en(CLK_EN),
    .din(FAULT_IN),
    .dout(fault_sync)
  );

  // Samples come from the same clock, so no synchroniser here
  assign smp[0] = SIG_A;
  assign smp[1] = SIG_B;

  // ----------------------------------------------------------------
  // Channel peak tracking and hysteresis
  // ----------------------------------------------------------------
  // Peaks only widen; the timed reset is what lets them follow a shrinking gap
  always_ff @(posedge CORE_CLK) begin
    for (int i = 0; i < 2; i++) begin
      if (SYS_RST || (CLK_EN && trst_hit)) begin
        pk_hi[i] <= `GTD_PK_HI_RST;
        pk_lo[i] <= `GTD_PK_LO_RST;
        ch[i] <= 1'b0;
        ch_q[i] <= 1'b0;
      end else if (CLK_EN) begin
        if (smp[i] > pk_hi[i]) begin
          pk_hi[i] <= smp[i];
        end
        if (smp[i] < pk_lo[i]) begin
          pk_lo[i] <= smp[i];
        end
        ch_q[i] <= ch[i];
        // Switch on at 70 percent, off at 30 percent
        if (!ch[i] && pk_hi[i] > pk_lo[i] &&
            smp[i] >= gtd_level(pk_lo[i], pk_hi[i], `GTD_ON_PCT)) begin
          ch[i] <= 1'b1;
        end else if (ch[i] && smp[i] <= gtd_level(pk_lo[i], pk_hi[i], `GTD_OFF_PCT)) begin
          ch[i] <= 1'b0;
        end
      end
    end
  end

  assign rise[0] = ch[0] & ~ch_q[0];
  assign rise[1] = ch[1] & ~ch_q[1];

  // ----------------------------------------------------------------
  // Direction from switching order
  // ----------------------------------------------------------------
  // B on since A last switched off; clearing on A rise would call both orders forward
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || (CLK_EN && trst_hit)) begin
      b_led <= 1'b0;
    end else if (CLK_EN) begin
      if (ch_q[0] && !ch[0]) begin
        b_led <= 1'b0;
      end else if (rise[1]) begin
        b_led <= 1'b1;
      end
    end
  end

  // B before A is one order, A before B the other; polarity flips it
  assign dir_fwd = b_led ^ ctrl[`GTD_CTRL_POL];

  // Each channel A switch-on is one tooth
  assign tooth = rise[0] & settled;

  // Tooth period; above the limit rate direction is dropped
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      per_cnt <= '0;
    end else if (CLK_EN) begin
      if (tooth) begin
        per_cnt <= `GTD_CW'(1);
      end else if (per_cnt != '1) begin
        per_cnt <= per_cnt + `GTD_CW'(1);
      end
    end
  end

  always_comb begin
    if (ctrl[`GTD_CTRL_INTER] && per_cnt < `GTD_CW'(DIRLIM_CYC)) begin
      next_kind = gtd_pkg::GTD_ND;
    end else if (dir_fwd) begin
      next_kind = gtd_pkg::GTD_FWD;
    end else begin
      next_kind = gtd_pkg::GTD_REV;
    end
  end

  // ----------------------------------------------------------------
  // Power-on settle, calibration and timed reset
  // ----------------------------------------------------------------
  // Teeth ignored until settled, so early transients never give a pulse; error frames are not held back
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      settle_cnt <= '0;
      settled <= 1'b0;
    end else if (CLK_EN && !settled) begin
      settle_cnt <= settle_cnt + `GTD_CW'(1);
      settled <= (settle_cnt == `GTD_CW'(SETTLE_CYC - 1));
    end
  end

  // The first teeth only prime the thresholds
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || (CLK_EN && trst_hit)) begin
      cal_cnt <= '0;
    end else if (CLK_EN && tooth && !calibrated) begin
      cal_cnt <= cal_cnt + 2'h1;
    end
  end
  assign calibrated = (cal_cnt == `GTD_CAL_TEETH);

  // Idle timer; trades zero-speed output for fresh thresholds
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      idle_cnt <= '0;
    end else if (CLK_EN) begin
      if (start || trst_hit || !ctrl[`GTD_CTRL_TRST]) begin
        idle_cnt <= '0;
      end else begin
        idle_cnt <= idle_cnt + `GTD_CW'(1);
      end
    end
  end
  assign trst_hit = ctrl[`GTD_CTRL_TRST] && idle_cnt == `GTD_CW'(TRST_CYC - 1);

  // ----------------------------------------------------------------
  // Fault monitor
  // ----------------------------------------------------------------
  // Both channels switching together breaks the order check; count it a defect
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      phase_err <= 1'b0;
    end else if (CLK_EN) begin
      if (ctrl[`GTD_CTRL_DIAG] && rise[0] && rise[1]) begin
        phase_err <= 1'b1;
      end else if (gap_done && cur_kind == gtd_pkg::GTD_ERR) begin
        phase_err <= 1'b0;
      end
    end
  end
  assign fault_now = ctrl[`GTD_CTRL_DIAG] && (fault_sync || phase_err);

  // Each error frame end is a recovery attempt; no retry limit
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      fault_state <= 1'b0;
      retry_cnt <= '0;
    end else if (CLK_EN) begin
      if (fault_now) begin
        fault_state <= 1'b1;
      end else if (gap_done && cur_kind == gtd_pkg::GTD_ERR) begin
        fault_state <= 1'b0;
      end
      if (gap_done && cur_kind == gtd_pkg::GTD_ERR && fault_now && retry_cnt != 8'hff) begin
        retry_cnt <= retry_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  // One tooth may wait during a pulse or gap; a further one takes its place
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pend <= 1'b0;
      pend_kind <= gtd_pkg::GTD_FWD;
      last_fwd <= 1'b0;
    end else if (CLK_EN) begin
      if (fault_state) begin
        pend <= 1'b0;
      end else if (tooth && calibrated) begin
        pend <= 1'b1;
        pend_kind <= next_kind;
        last_fwd <= dir_fwd;
      end else if (start) begin
        pend <= 1'b0;
      end
    end
  end

  assign start = (ost == gtd_pkg::GTD_IDLE) && (fault_state || pend);
  assign gap_done = (ost == gtd_pkg::GTD_GAP) && (tcnt == gtd_gap(cur_kind));

  // High for the kind's count, then low for at least the gap
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ost <= gtd_pkg::GTD_IDLE;
      cur_kind <= gtd_pkg::GTD_FWD;
      tcnt <= '0;
      PULSE_OUT <= 1'b0;
    end else if (CLK_EN) begin
      unique case (ost)
        gtd_pkg::GTD_IDLE: begin
          if (start) begin
            cur_kind <= fault_state ? gtd_pkg::GTD_ERR : pend_kind;
            PULSE_OUT <= 1'b1;
            tcnt <= `GTD_CW'(1);
            ost <= gtd_pkg::GTD_HIGH;
          end
        end
        gtd_pkg::GTD_HIGH: begin
          if (tcnt == gtd_len(cur_kind)) begin
            PULSE_OUT <= 1'b0;
            tcnt <= `GTD_CW'(1);
            ost <= gtd_pkg::GTD_GAP;
          end else begin
            tcnt <= tcnt + `GTD_CW'(1);
          end
        end
        gtd_pkg::GTD_GAP: begin
          if (gap_done) begin
            ost <= gtd_pkg::GTD_IDLE;
          end else begin
            tcnt <= tcnt + `GTD_CW'(1);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Control bits steer polarity, rate option, diagnostics and timed reset
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl <= `GTD_CTRL_RST;
    end else if (CLK_EN && WR && ADDR == `GTD_REG_CTRL) begin
      ctrl <= WDATA[3:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pulse_cnt <= '0;
    end else if (CLK_EN && start && !fault_state) begin
      pulse_cnt <= pulse_cnt + 16'h0001;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RDATA <= '0;
    end else if (CLK_EN) begin
      RDATA <= '0;
      if (RD) begin
        unique case (ADDR)
          `GTD_REG_CTRL: RDATA <= {28'h0000000, ctrl};
          `GTD_REG_STATUS: RDATA <= {16'h0000, retry_cnt, 4'h0, calibrated, settled,
                                     fault_state, last_fwd};
          `GTD_REG_COUNT: RDATA <= {16'h0000, pulse_cnt};
          default: RDATA <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [`GTD_CW-1:0] hi_len;
  logic [`GTD_CW-1:0] lo_len;

  // Independent high and low time meters on the output
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      hi_len <= '0;
      lo_len <= '1;
    end else if (CLK_EN) begin
      hi_len <= PULSE_OUT ? hi_len + `GTD_CW'(1) : '0;
      lo_len <= PULSE_OUT ? '0 : ((&lo_len) ? lo_len : lo_len + `GTD_CW'(1));
    end
  end

  fwd_width_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $fell(PULSE_OUT) && cur_kind == gtd_pkg::GTD_FWD |-> hi_len == `GTD_CW'(`GTD_FWD_CYC))
    else $error("forward pulse width wrong");
  rev_width_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $fell(PULSE_OUT) && cur_kind == gtd_pkg::GTD_REV |-> hi_len == `GTD_CW'(`GTD_REV_CYC))
    else $error("reverse pulse width wrong");
  nd_width_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $fell(PULSE_OUT) && cur_kind == gtd_pkg::GTD_ND |-> hi_len == `GTD_CW'(`GTD_ND_CYC))
    else $error("non-direction pulse width wrong");
  pulse_gap_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(PULSE_OUT) |-> $past(lo_len) >= `GTD_CW'(`GTD_SEP_CYC))
    else $error("pulse gap too short");
  settle_quiet_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !settled |-> !PULSE_OUT)
    else $error("pulse before settling");
  error_frame_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && fault_state && ost == gtd_pkg::GTD_IDLE |=> PULSE_OUT && cur_kind == gtd_pkg::GTD_ERR)
    else $error("fault without error frame");
  retry_clear_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && gap_done && cur_kind == gtd_pkg::GTD_ERR && !fault_now |=> !fault_state)
    else $error("recovery not taken");
  dir_order_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && tooth && calibrated && !fault_state |=> last_fwd == ($past(b_led) ^ ctrl[`GTD_CTRL_POL]))
    else $error("direction order wrong");
  timed_reset_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && trst_hit |=> cal_cnt == 2'h0 && idle_cnt == '0)
    else $error("timed reset missed");
  one_tooth_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && tooth && calibrated && !fault_state && !pend |=> pend)
    else $error("tooth not queued");
endmodule

// >>> gtd_pkg.sv
// Types shared by the gear-tooth encoder
package gtd_pkg;
  typedef enum logic [1:0] {GTD_FWD, GTD_REV, GTD_ND, GTD_ERR} gtd_kind_t;
  typedef enum {GTD_IDLE, GTD_HIGH, GTD_GAP} gtd_out_t;
endpackage

// >>> gtd_sync.sv
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module gtd_sync (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic en, // Clock enable
  input wire logic din, // Asynchronous pin level
  output logic dout // Filtered level
);
  logic s1;
  logic s2;
  logic s3;

  // Only s2 reads s1; a level counts once s2 and s3 agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else if (en) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// >>> gtd_tb.sv
// Self-checking testbench for the gear-tooth encoder
`timescale 1ns/1ps
`include "gtd_cfg.svh"
module tb;
  localparam int SETTLE = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic fault_in = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] sig_a = 8'h00;
  logic [7:0] sig_b = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic [31:0] d;
  logic pulse_out;
  int n_kind [4];
  int n_odd;
  int base [4];
  int bad_count = 0;
  int samples_checked = 0;
  gtd_pkg::gtd_kind_t exp_q [$];

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  // Short counts keep the run small; expectations use the same values
  gtd_encoder #(.SETTLE_CYC(SETTLE), .TRST_CYC(500), .DIRLIM_CYC(100)) uut (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .SIG_A(sig_a),
    .SIG_B(sig_b), .FAULT_IN(fault_in), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PULSE_OUT(pulse_out));

  gtd_ctl_model #(.SETTLE_CYC(SETTLE)) ctl (
    .clk(core_clk), .rst(sys_rst), .pulse(pulse_out), .n_kind(n_kind), .n_odd(n_odd));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(rdata & m, want);
  endtask

  // One tooth in four quarters; forward order lets B switch on before A
  task automatic tooth(input int p, input bit fwd, input int kind);
    logic [7:0] h;
    logic [7:0] l;
    int q;
    h = 8'he0 | 8'($urandom % 32);
    l = 8'($urandom % 32);
    if (kind >= 0) exp_q.push_back(gtd_pkg::gtd_kind_t'(kind));
    for (q = 0; q < 4; q++) begin
      @(posedge core_clk);
      sig_a <= (fwd ? (q == 1 || q == 2) : (q < 2)) ? h : l;
      sig_b <= (fwd ? (q < 2) : (q == 1 || q == 2)) ? h : l;
      repeat (p / 4 - 1) @(posedge core_clk);
    end
  endtask

  task automatic open_phase();
    base = n_kind;
    exp_q.delete();
  endtask

  // Compare pulses per kind seen by the controller with the teeth sent
  task automatic close_phase();
    int want [4] = '{default: 0};
    foreach (exp_q[i]) want[exp_q[i]]++;
    for (int k = 0; k < 4; k++) chk(n_kind[k] - base[k], want[k]);
  endtask

  // Calibration may eat some teeth, but a pulse must come within four
  task automatic warm_up();
    open_phase();
    repeat (4) tooth(1000, 1'b1, -1);
    chk(32'(n_kind[0] > base[0]), 32'h1);
  endtask

  task automatic end_of_test();
    $display("Comparisons: %0d, mismatches: %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog, well beyond the roughly 60000 cycles the tests need
  // ----------------------------------------------------------------
  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    $display("[ERR] %0t ns: run did not finish", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(98));
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(`GTD_REG_CTRL, 32'hffffffff, 32'h0);
    rd_chk(`GTD_REG_COUNT, 32'hffffffff, 32'h0);
    rd_chk(8'h0c, 32'hffffffff, 32'h0);
    // A write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr_reg(`GTD_REG_CTRL, 32'hf);
    clk_en <= 1'b1;
    rd_chk(`GTD_REG_CTRL, 32'hffffffff, 32'h0);
    d = $urandom;
    wr_reg(`GTD_REG_CTRL, d);
    rd_chk(`GTD_REG_CTRL, 32'hffffffff, {28'h0, d[3:0]});
    wr_reg(`GTD_REG_CTRL, 32'h0);
    repeat (SETTLE) @(posedge core_clk);
    warm_up();
    // Steady forward, then reverse, then forward motion with polarity swapped
    open_phase();
    repeat (4) tooth(1000, 1'b1, 0);
    close_phase();
    rd_chk(`GTD_REG_STATUS, 32'hd, 32'hd);
    open_phase();
    repeat (4) tooth(2500, 1'b0, 1);
    close_phase();
    rd_chk(`GTD_REG_STATUS, 32'h1, 32'h0);
    wr_reg(`GTD_REG_CTRL, 32'h1);
    open_phase();
    repeat (3) tooth(2500, 1'b1, 1);
    close_phase();
    wr_reg(`GTD_REG_CTRL, 32'h0);
    rd_chk(`GTD_REG_COUNT, 32'hffff, n_kind[0] + n_kind[1]);
    // Fast teeth with the intermediate option drop direction
    wr_reg(`GTD_REG_CTRL, 32'h2);
    open_phase();
    repeat (30) tooth(80, 1'b1, -1);
    repeat (8000) @(posedge core_clk);
    chk(32'(n_kind[2] > base[2]), 32'h1);
    // A fault held across one frame end forces one retry, then clears
    wr_reg(`GTD_REG_CTRL, 32'h4);
    open_phase();
    @(posedge core_clk);
    fault_in <= 1'b1;
    repeat (50) @(posedge core_clk);
    rd_chk(`GTD_REG_STATUS, 32'h2, 32'h2);
    repeat (7450) @(posedge core_clk);
    fault_in <= 1'b0;
    repeat (7600) @(posedge core_clk);
    rd_chk(`GTD_REG_STATUS, 32'hff02, 32'h0100);
    exp_q.push_back(gtd_pkg::GTD_ERR);
    exp_q.push_back(gtd_pkg::GTD_ERR);
    close_phase();
    // Idle with timed reset on loses calibration, which then comes back
    wr_reg(`GTD_REG_CTRL, 32'h0);
    rd_chk(`GTD_REG_STATUS, 32'h8, 32'h8);
    wr_reg(`GTD_REG_CTRL, 32'h8);
    repeat (1200) @(posedge core_clk);
    rd_chk(`GTD_REG_STATUS, 32'h8, 32'h0);
    wr_reg(`GTD_REG_CTRL, 32'h0);
    warm_up();
    chk(n_odd, 32'h0);
    end_of_test();
  end
endmodule
